// ---- rtl/slider_status_regs.sv ----
// Slider result, volume step, noise and lid status registers
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module slider_status_regs #(
  parameter int NSENS = slider_status_pkg::NUM_SENSORS,
  parameter logic [7:0] MAKER_ID = slider_status_pkg::MAKER_ID_DEFAULT
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Power state and alert
  input wire logic DEEP_SLEEP,
  input wire logic ALERT_EVENT,
  // Slider gestures, pulses at each interrupt or repeat
  input wire logic SLIDE_UP,
  input wire logic SLIDE_DOWN,
  input wire logic TAP_UP,
  input wire logic TAP_DOWN,
  input wire logic HOLD_UP,
  input wire logic HOLD_DOWN,
  input wire logic [2:0] LAST_SLIDER_INDEX,
  input wire logic [3:0] FINE_OFFSET,
  input wire logic FINE_TOWARD_UP,
  // Analog detector status per sensor
  input wire logic [13:0] OVERRANGE_NOISE,
  input wire logic [13:0] RF_NOISE,
  input wire logic [13:0] LF_NOISE,
  input wire logic [13:0] TOUCH_DETECTED,
  input wire logic [13:0] LID_ABOVE_QUEUED,
  input wire logic [13:0] LID_PATTERN,
  // Per-sensor decisions and lid event
  output logic [13:0] SAMPLE_USE,
  output logic LID_MATCH
);
  import slider_status_pkg::*;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [6:0] result_reg;
  logic [6:0] result_next;
  logic [3:0] step_reg;
  logic [3:0] cfg_reg;
  logic [7:0] noise_low_reg;
  logic [6:0] noise_high_reg;
  logic [13:0] lid_reg;
  logic [13:0] use_reg;
  logic match_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic present_vol;
  logic wr_result;
  logic rd_result;
  logic wr_step;
  logic wr_cfg;
  logic [6:0] position;

  assign present_vol = cfg_reg[CFG_PRESENT_BIT];
  assign wr_result = REG_WR && (REG_ADDR == ADDR_SLIDER_RESULT);
  assign rd_result = REG_RD && (REG_ADDR == ADDR_SLIDER_RESULT);
  assign wr_step = REG_WR && (REG_ADDR == ADDR_VOLUME_STEP_SIZE);
  assign wr_cfg = REG_WR && (REG_ADDR == ADDR_RESULT_CONFIG);

  // ----------------------------------------------------------------
  // Absolute position
  // ----------------------------------------------------------------
  // Interpolator on last touched sensor
  slider_position_calc u_pos (
    .CLK(CLK),
    .SRST(SRST),
    .slider_touch(TOUCH_DETECTED[13:7]),
    .last_index(LAST_SLIDER_INDEX),
    .fine_offset(FINE_OFFSET),
    .fine_toward_up(FINE_TOWARD_UP),
    .position(position)
  );

  // ----------------------------------------------------------------
  // Volumetric arithmetic
  // ----------------------------------------------------------------
  logic [7:0] vol_up_amt;
  logic [7:0] vol_dn_amt;
  logic [7:0] vol_sum;
  logic [7:0] vol_sat;
  logic vol_event;
  assign vol_up_amt = SLIDE_UP ? {4'h0, step_reg} : ((TAP_UP || HOLD_UP) ? 8'h01 : 8'h00);
  // Tap and hold step by one
  assign vol_dn_amt = SLIDE_DOWN ? {4'h0, step_reg} : ((TAP_DOWN || HOLD_DOWN) ? 8'h01 : 8'h00);
  assign vol_event = (vol_up_amt != 8'h00) || (vol_dn_amt != 8'h00);
  assign vol_sum = {1'b0, result_reg} + vol_up_amt;
  assign vol_sat = (vol_dn_amt > vol_sum) ? {1'b0, VOLUME_MIN} :
                   ((vol_sum - vol_dn_amt) > {1'b0, VOLUME_MAX}) ? {1'b0, VOLUME_MAX} : vol_sum - vol_dn_amt;

  // Next slider result, sleep first, then events, then host
  always_comb begin
    result_next = result_reg;
    if (DEEP_SLEEP) begin
      result_next = 7'h00;
    end else if (present_vol) begin
      if (wr_result) begin
        result_next = (REG_WDATA[6:0] > VOLUME_MAX) ? VOLUME_MAX : REG_WDATA[6:0];
      end
      if (vol_event) begin
        result_next = vol_sat[6:0];
      end
    end else begin
      if (rd_result) begin
        result_next = 7'h00;
      end
      if (ALERT_EVENT) begin
        result_next = position;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      result_reg <= SLIDER_RESULT_RESET[6:0];
    end else begin
      result_reg <= result_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      step_reg <= VOLUME_STEP_RESET;
      cfg_reg <= 4'h0;
    end else begin
      if (wr_step) begin
        step_reg <= REG_WDATA[3:0];
      end
      if (wr_cfg) begin
        cfg_reg <= REG_WDATA[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Noise and lid status
  // ----------------------------------------------------------------
  logic [13:0] noise_any;
  logic [13:0] noisy_flag;
  logic [13:0] use_next;
  logic [13:0] lid_next;
  genvar g;
  generate
    for (g = 0; g < 14; g++) begin : g_sens
      // RF noise ORed except sensor zero
      if (g == 0) begin : g_first
        assign noisy_flag[g] = OVERRANGE_NOISE[g];
      end else begin : g_rest
        assign noisy_flag[g] = OVERRANGE_NOISE[g] || RF_NOISE[g];
      end
      assign noise_any[g] = OVERRANGE_NOISE[g] || RF_NOISE[g];
      // Gate decisions by noise and keep bits
      assign use_next[g] = !noise_any[g] &&
                           !(LF_NOISE[g] && !cfg_reg[CFG_KEEP_LF_BIT]) &&
                           !(RF_NOISE[g] && !cfg_reg[CFG_KEEP_RF_BIT]);
      // Lid flag from queued compare or touch
      assign lid_next[g] = cfg_reg[CFG_LID_EN_BIT] && (LID_ABOVE_QUEUED[g] || TOUCH_DETECTED[g]);
    end
  endgenerate

  // Noise flags track detector each cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      noise_low_reg <= 8'h00;
      noise_high_reg <= 7'h00;
      lid_reg <= 14'h0000;
      use_reg <= 14'h0000;
      match_reg <= 1'b0;
    end else begin
      noise_low_reg <= {RF_NOISE[0], noisy_flag[6:0]};
      noise_high_reg <= noisy_flag[13:7];
      lid_reg <= lid_next;
      use_reg <= use_next;
      match_reg <= (LID_PATTERN != 14'h0000) && ((lid_next & LID_PATTERN) == LID_PATTERN);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    case (REG_ADDR)
      ADDR_SLIDER_RESULT: rdata_next = {1'b0, result_reg};
      ADDR_VOLUME_STEP_SIZE: rdata_next = {4'h0, step_reg};
      ADDR_NOISE_FLAGS_LOW: rdata_next = noise_low_reg;
      ADDR_NOISE_FLAGS_HIGH: rdata_next = {1'b0, noise_high_reg};
      ADDR_LID_FLAGS_LOW: rdata_next = {1'b0, lid_reg[6:0]};
      ADDR_LID_FLAGS_HIGH: rdata_next = {1'b0, lid_reg[13:7]};
      ADDR_RESULT_CONFIG: rdata_next = {4'h0, cfg_reg};
      ADDR_MAKER_IDENTIFIER: rdata_next = MAKER_ID;
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data register, valid the cycle after a read strobe
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_reg <= 8'h00;
    end else if (REG_RD) begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign SAMPLE_USE = use_reg;
  assign LID_MATCH = match_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Result register and presentation
  a_sleep_clears: assert property (@(posedge CLK) disable iff (SRST) DEEP_SLEEP |=> result_reg == 7'h00)
    else $error("slider result not cleared in deep sleep");
  a_abs_read_clear: assert property (@(posedge CLK) disable iff (SRST)
    (rd_result && !present_vol && !ALERT_EVENT && !DEEP_SLEEP) |=> result_reg == 7'h00)
    else $error("absolute result not cleared by read");
  a_alert_loads: assert property (@(posedge CLK) disable iff (SRST)
    (ALERT_EVENT && !present_vol && !DEEP_SLEEP) |=> result_reg == $past(position))
    else $error("alert did not load position");
  a_pos_range: assert property (@(posedge CLK) disable iff (SRST)
    (ALERT_EVENT && !present_vol && !DEEP_SLEEP && !$past(SRST))
    |=> (result_reg >= POSITION_MIN) && (result_reg <= POSITION_MAX))
    else $error("absolute position outside slider span");
  a_abs_no_write: assert property (@(posedge CLK) disable iff (SRST)
    (!present_vol && !rd_result && !ALERT_EVENT && !DEEP_SLEEP) |=> $stable(result_reg))
    else $error("absolute result changed without read or alert");

  // Volumetric arithmetic and host preset
  a_vol_range: assert property (@(posedge CLK) disable iff (SRST) present_vol |-> result_reg <= VOLUME_MAX)
    else $error("volume above range");
  a_tap_one: assert property (@(posedge CLK) disable iff (SRST)
    (present_vol && TAP_UP && !SLIDE_UP && !SLIDE_DOWN && !TAP_DOWN && !HOLD_DOWN && !DEEP_SLEEP
     && result_reg < VOLUME_MAX) |=> result_reg == $past(result_reg) + 7'h01)
    else $error("tap did not raise volume by one");
  a_hold_down_one: assert property (@(posedge CLK) disable iff (SRST)
    (present_vol && HOLD_DOWN && !SLIDE_UP && !SLIDE_DOWN && !TAP_UP && !HOLD_UP && !DEEP_SLEEP
     && result_reg > VOLUME_MIN) |=> result_reg == $past(result_reg) - 7'h01)
    else $error("hold did not lower volume by one");
  a_slide_up_step: assert property (@(posedge CLK) disable iff (SRST)
    (present_vol && SLIDE_UP && !SLIDE_DOWN && !TAP_DOWN && !HOLD_DOWN && !DEEP_SLEEP
     && ({1'b0, result_reg} + {4'h0, step_reg}) <= {1'b0, VOLUME_MAX})
    |=> result_reg == $past(result_reg) + {3'h0, $past(step_reg)})
    else $error("up slide did not add the step");
  a_slide_down_step: assert property (@(posedge CLK) disable iff (SRST)
    (present_vol && SLIDE_DOWN && !SLIDE_UP && !TAP_UP && !HOLD_UP && !DEEP_SLEEP
     && result_reg >= {3'h0, step_reg})
    |=> result_reg == $past(result_reg) - {3'h0, $past(step_reg)})
    else $error("down slide did not subtract the step");
  a_vol_floor: assert property (@(posedge CLK) disable iff (SRST)
    (present_vol && SLIDE_DOWN && !SLIDE_UP && !TAP_UP && !HOLD_UP && !DEEP_SLEEP
     && result_reg < {3'h0, step_reg}) |=> result_reg == VOLUME_MIN)
    else $error("volume fell below zero");
  a_host_preset: assert property (@(posedge CLK) disable iff (SRST)
    (present_vol && wr_result && !vol_event && !DEEP_SLEEP && REG_WDATA[6:0] <= VOLUME_MAX)
    |=> result_reg == $past(REG_WDATA[6:0]))
    else $error("host preset of volume lost");
  a_step_reset: assert property (@(posedge CLK) $fell(SRST) |-> step_reg == VOLUME_STEP_RESET)
    else $error("step reset value wrong");
  a_step_write: assert property (@(posedge CLK) disable iff (SRST)
    wr_step |=> step_reg == $past(REG_WDATA[3:0]))
    else $error("step write lost");

  // Noise, lid and identifier
  a_noise_follow: assert property (@(posedge CLK) disable iff (SRST)
    ##1 noise_high_reg == $past(OVERRANGE_NOISE[13:7] | RF_NOISE[13:7]))
    else $error("noise flags not following detector");
  a_overrange_sets: assert property (@(posedge CLK) disable iff (SRST)
    ##1 (noise_high_reg & $past(OVERRANGE_NOISE[13:7])) == $past(OVERRANGE_NOISE[13:7]))
    else $error("overrange did not set noise flag");
  a_first_rf_bit: assert property (@(posedge CLK) disable iff (SRST)
    ##1 (noise_low_reg[7] == $past(RF_NOISE[0])) && (noise_low_reg[0] == $past(OVERRANGE_NOISE[0])))
    else $error("first channel noise bits mixed");
  a_noisy_unused: assert property (@(posedge CLK) disable iff (SRST) OVERRANGE_NOISE[0] |=> !SAMPLE_USE[0])
    else $error("noisy sample used");
  a_noise_blocks: assert property (@(posedge CLK) disable iff (SRST)
    ##1 (SAMPLE_USE & $past(OVERRANGE_NOISE | RF_NOISE)) == 14'h0000)
    else $error("noisy sensor still used");
  a_lf_discard: assert property (@(posedge CLK) disable iff (SRST)
    !cfg_reg[CFG_KEEP_LF_BIT] |=> (SAMPLE_USE & $past(LF_NOISE)) == 14'h0000)
    else $error("low frequency noisy sample used");
  a_clean_used: assert property (@(posedge CLK) disable iff (SRST)
    (!OVERRANGE_NOISE[0] && !RF_NOISE[0] && !LF_NOISE[0]) |=> SAMPLE_USE[0])
    else $error("clean sample discarded");
  a_lid_enable: assert property (@(posedge CLK) disable iff (SRST) !cfg_reg[CFG_LID_EN_BIT] |=> lid_reg == 14'h0000)
    else $error("lid flag set while disabled");
  a_touch_lid: assert property (@(posedge CLK) disable iff (SRST)
    cfg_reg[CFG_LID_EN_BIT] |=> (lid_reg & $past(TOUCH_DETECTED)) == $past(TOUCH_DETECTED))
    else $error("touch did not set lid flag");
  a_lid_clears: assert property (@(posedge CLK) disable iff (SRST)
    (!LID_ABOVE_QUEUED[0] && !TOUCH_DETECTED[0]) |=> !lid_reg[0])
    else $error("lid flag latched");
  a_lid_match: assert property (@(posedge CLK) disable iff (SRST)
    (cfg_reg[CFG_LID_EN_BIT] && LID_PATTERN != 14'h0000 && (LID_ABOVE_QUEUED & LID_PATTERN) == LID_PATTERN)
    |=> LID_MATCH)
    else $error("lid pattern covered but no match");
  a_lid_nomatch: assert property (@(posedge CLK) disable iff (SRST)
    LID_PATTERN == 14'h0000 |=> !LID_MATCH)
    else $error("match flagged with empty pattern");
  a_maker_read: assert property (@(posedge CLK) disable iff (SRST)
    (REG_RD && REG_ADDR == ADDR_MAKER_IDENTIFIER) |=> REG_RDATA == MAKER_ID)
    else $error("maker identifier read wrong");
endmodule // slider_status_regs

// ---- rtl/slider_status_pkg.sv ----
// Package: register map, field layout and reset values of the slider/noise/lid status block
package slider_status_pkg;
  localparam int NUM_SENSORS = 14;
  localparam logic [7:0] ADDR_SLIDER_RESULT = 8'h06;
  localparam logic [7:0] ADDR_VOLUME_STEP_SIZE = 8'h09;
  localparam logic [7:0] ADDR_NOISE_FLAGS_LOW = 8'h0A;
  localparam logic [7:0] ADDR_NOISE_FLAGS_HIGH = 8'h0B;
  localparam logic [7:0] ADDR_LID_FLAGS_LOW = 8'h0C;
  localparam logic [7:0] ADDR_LID_FLAGS_HIGH = 8'h0D;
  localparam logic [7:0] ADDR_RESULT_CONFIG = 8'h40;
  localparam logic [7:0] ADDR_MAKER_IDENTIFIER = 8'hFE;
  localparam logic [7:0] SLIDER_RESULT_RESET = 8'h00;
  localparam logic [3:0] VOLUME_STEP_RESET = 4'h1;
  localparam logic [6:0] VOLUME_MIN = 7'h00;
  localparam logic [6:0] VOLUME_MAX = 7'h64;
  localparam logic [6:0] POSITION_MIN = 7'h02;
  localparam logic [6:0] POSITION_MAX = 7'h62;
  localparam logic [6:0] POSITION_PITCH = 7'h10;
  localparam logic [7:0] MAKER_ID_DEFAULT = 8'hA7; // arbitrary value
  localparam int CFG_PRESENT_BIT = 0;
  localparam int CFG_KEEP_LF_BIT = 1;
  localparam int CFG_KEEP_RF_BIT = 2;
  localparam int CFG_LID_EN_BIT = 3;
endpackage

// ---- rtl/slider_position_calc.sv ----
// Interpolated absolute slider position from up to two neighbouring sensors
`timescale 1ns/1ps
module slider_position_calc (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Touch inputs
  input wire logic [6:0] slider_touch,
  input wire logic [2:0] last_index,
  input wire logic [3:0] fine_offset,
  input wire logic fine_toward_up,
  // Result
  output logic [6:0] position
);
  import slider_status_pkg::*;
  logic [6:0] centre;
  logic [6:0] raw;
  logic [6:0] pos_reg;
  logic [6:0] pos_next;
  logic has_lower;
  logic has_upper;
  // Centre of last touched sensor plus/minus fine step
  assign centre = POSITION_MIN + 7'(last_index) * POSITION_PITCH;
  assign has_lower = (last_index != 3'd0) && slider_touch[last_index - 3'd1];
  assign has_upper = (last_index != 3'd6) && slider_touch[last_index + 3'd1];
  assign raw = (fine_toward_up && has_upper) ? centre + 7'(fine_offset) :
               (!fine_toward_up && has_lower) ? centre - 7'(fine_offset) : centre;
  assign pos_next = (raw < POSITION_MIN) ? POSITION_MIN : (raw > POSITION_MAX) ? POSITION_MAX : raw;
  // Result register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pos_reg <= 7'h00;
    end else begin
      pos_reg <= pos_next;
    end
  end
  assign position = pos_reg;
endmodule // slider_position_calc

// ---- bench/host_model.sv ----
// Host-side master for the plain register port
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // Idle bus from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // Stale data never looks valid
  endtask
  // Read cycle, data taken in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule // host_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the slider, noise and lid status registers
`timescale 1ns/1ps
module tb_top;
  import slider_status_pkg::*;
  localparam logic [7:0] MID = 8'h3C; // arbitrary value
  logic clk, srst, toward_up;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, evs;
  logic reg_wr, reg_rd, lid_match;
  logic [2:0] idx;
  logic [3:0] off, step, cfg;
  logic [13:0] ov, rf, lf, touch, above, pat, use_seen, use_exp, flags;
  int n_mismatch, checks, vol, k;

  host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  slider_status_regs #(.NSENS(NUM_SENSORS), .MAKER_ID(MID)) uut (.CLK(clk), .SRST(srst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .DEEP_SLEEP(evs[7]),
    .ALERT_EVENT(evs[6]), .SLIDE_UP(evs[0]), .SLIDE_DOWN(evs[1]), .TAP_UP(evs[2]), .TAP_DOWN(evs[3]),
    .HOLD_UP(evs[4]), .HOLD_DOWN(evs[5]), .LAST_SLIDER_INDEX(idx), .FINE_OFFSET(off), .FINE_TOWARD_UP(toward_up),
    .OVERRANGE_NOISE(ov), .RF_NOISE(rf), .LF_NOISE(lf), .TOUCH_DETECTED(touch), .LID_ABOVE_QUEUED(above),
    .LID_PATTERN(pat), .SAMPLE_USE(use_seen), .LID_MATCH(lid_match));

  // Free-running clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // Compare, expectation and stimulus tasks
  // ----------------------------------------
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD reg %h expected %h seen %h", a, e, s);
    end
  endtask
  task automatic chk_pin(input string n, input logic [13:0] e, input logic [13:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk_reg(a, e, d);
  endtask
  // One-cycle event pulse on bit b
  task automatic pulse(input int b);
    @(posedge clk);
    evs <= 8'h01 << b;
    @(posedge clk);
    evs <= 8'h00;
  endtask
  // Saturated volume after event b: slides move by step, taps and holds by one
  function automatic int vol_next(input int v, input int b, input int s);
    int dv;
    dv = (b < 2) ? s : 1;
    if (b % 2) dv = -dv;
    v = v + dv;
    return (v < 0) ? 0 : (v > 100) ? 100 : v;
  endfunction
  // Interpolated position: offset only toward a touched neighbour, clamped to the slider span
  function automatic logic [7:0] pos_exp(input logic [2:0] i, input logic [3:0] o, input logic u,
    input logic [6:0] t);
    int p;
    p = 2 + 16 * int'(i);
    if (u && i < 3'd6 && t[i + 3'd1]) p = p + int'(o);
    if (!u && i > 3'd0 && t[i - 3'd1]) p = p - int'(o);
    if (p < 2) p = 2;
    if (p > 98) p = 98;
    return 8'(p);
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {srst, toward_up, evs, idx, off, ov, rf, lf, touch, above, pat} = '0;
    srst = 1'b1;
    void'($urandom(32'h9B23));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rdchk(ADDR_SLIDER_RESULT, 8'h00); // reset value
    rdchk(ADDR_VOLUME_STEP_SIZE, 8'h01); // step reset
    host.wr(ADDR_MAKER_IDENTIFIER, 8'h00);
    rdchk(ADDR_MAKER_IDENTIFIER, MID); // read only
    rdchk(8'h20, 8'h00);
    $display("test reset done");
    host.wr(ADDR_RESULT_CONFIG, 8'h01);
    host.wr(ADDR_SLIDER_RESULT, 8'd120);
    rdchk(ADDR_SLIDER_RESULT, 8'd100); // write clamp
    host.wr(ADDR_SLIDER_RESULT, 8'd98);
    rdchk(ADDR_SLIDER_RESULT, 8'd98); // host preset
    vol = 98;
    step = 4'hF;
    host.wr(ADDR_VOLUME_STEP_SIZE, 8'h0F);
    for (int n = 0; n < 60; n++) begin
      if (n > 2 && n % 8 == 0) begin
        step = 4'($urandom);
        host.wr(ADDR_VOLUME_STEP_SIZE, {4'h0, step});
        rdchk(ADDR_VOLUME_STEP_SIZE, {4'h0, step}); // step field
      end
      k = (n < 2) ? n : int'($urandom % 6);
      pulse(k);
      vol = vol_next(vol, k, int'(step));
      rdchk(ADDR_SLIDER_RESULT, 8'(vol)); // volume
    end
    pulse(7);
    rdchk(ADDR_SLIDER_RESULT, 8'h00); // deep sleep
    $display("test volume done");
    host.wr(ADDR_RESULT_CONFIG, 8'h00);
    for (int n = 0; n < 24; n++) begin
      @(posedge clk);
      idx <= 3'($urandom % 7);
      off <= 4'($urandom);
      toward_up <= 1'($urandom);
      touch <= 14'($urandom);
      repeat (2) @(posedge clk);
      pulse(6);
      if (n % 2) pulse(6);
      rdchk(ADDR_SLIDER_RESULT, pos_exp(idx, off, toward_up, touch[13:7])); // position
      rdchk(ADDR_SLIDER_RESULT, 8'h00); // read clears
    end
    $display("test position done");
    for (int n = 0; n < 40; n++) begin
      cfg = 4'($urandom) & 4'hE;
      host.wr(ADDR_RESULT_CONFIG, {4'h0, cfg});
      @(posedge clk);
      if (n > 0) begin
        ov <= 14'($urandom & $urandom);
        rf <= 14'($urandom & $urandom);
        lf <= 14'($urandom);
        touch <= 14'($urandom & $urandom);
        above <= 14'($urandom | $urandom);
        pat <= 14'($urandom & $urandom & $urandom);
      end
      repeat (3) @(posedge clk);
      flags = ov | rf;
      rdchk(ADDR_NOISE_FLAGS_LOW, {rf[0], flags[6:1], ov[0]}); // noise low
      rdchk(ADDR_NOISE_FLAGS_HIGH, {1'b0, flags[13:7]}); // noise high
      use_exp = ~(ov | rf) & ~(lf & {14{~cfg[CFG_KEEP_LF_BIT]}}) & ~(rf & {14{~cfg[CFG_KEEP_RF_BIT]}});
      chk_pin("sample use", use_exp, use_seen); // sample gating
      flags = cfg[CFG_LID_EN_BIT] ? (above | touch) : 14'h0;
      rdchk(ADDR_LID_FLAGS_LOW, {1'b0, flags[6:0]}); // lid low
      rdchk(ADDR_LID_FLAGS_HIGH, {1'b0, flags[13:7]}); // lid high
      chk_pin("lid match", {13'h0, pat != 0 && (flags & pat) == pat}, {13'h0, lid_match}); // pattern
    end
    $display("test noise and lid done");
    summarize();
  end
endmodule // tb_top
